//--- include/clock_mode_consts.svh
`ifndef CLOCK_MODE_CONSTS_SVH
`define CLOCK_MODE_CONSTS_SVH
`define OFS_CTRL1 12'h000
`define OFS_CTRL2 12'h004
`define OFS_STATUS 12'h008
`define OFS_LOOP 12'h00c
`define C1_HIGH_GAIN 7
`define C1_RANGE 6
`define C1_REF_SEL 5
`define C1_SEL 4:3
`define C1_SEL_HI 4
`define C2_MULT 6:4
`define C2_DIV 2:0
`define SEL_SELF 2'h0
`define SEL_LOOP_INT 2'h1
`define SEL_BYPASS 2'h2
`define SEL_LOOP_EXT 2'h3
`define CODE_OFF 2'h0
`define SETTLE_CYCLES 4
`define N_BASE 5'h04
`define P_LOW_SHIFT 6
`define RATIO_MIN 12'h004
`define REF_DIV_INT 3'h7
`define REF_DIV_EXT 3'h1
`define FIELD3_RST 3'h0
`define FIXED_HALF 4'h1
`define FIXED_FULL 4'h0
`define SYNC_W 5
`endif

//--- include/clock_mode_pkg.sv
package clock_mode_pkg;
    typedef enum logic [2:0] {
        M_SELF = 3'h0,
        M_LOOP_INT = 3'h1,
        M_LOOP_EXT = 3'h3,
        M_BYPASS = 3'h2,
        M_OFF = 3'h6
    } clk_mode_t;
endpackage

//--- core/tick_divider.sv
`timescale 1ns/1ps
module tick_divider #(
    parameter int SHIFT_W = 4,
    parameter int CNT_W = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic en_in,
    input wire logic tick_in,
    input wire logic [SHIFT_W-1:0] shift_in,
    output logic tick_out
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] mask;

    if (SHIFT_W < 1 || CNT_W < 1 || (1 << SHIFT_W) > CNT_W + 8) begin : g_width_check
        $error("tick_divider: unsupported widths");
    end

    // terminal count is 2**shift - 1
    assign mask = CNT_W'(({{CNT_W{1'b0}}, 1'b1} << shift_in) - 1'b1);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= '0;
            tick_out <= 1'b0;
        end else if (!en_in) begin
            count_r <= '0;
            tick_out <= 1'b0;
        end else if (tick_in) begin
            if (count_r >= mask) begin
                count_r <= '0;
                tick_out <= 1'b1;
            end else begin
                count_r <= count_r + 1'b1;
                tick_out <= 1'b0;
            end
        end else begin
            tick_out <= 1'b0;
        end
    end
endmodule

//--- core/clock_mode_select_and_status.sv
`timescale 1ns/1ps
`include "clock_mode_consts.svh"
// Behaviour
// - two-bit request and granted status, 00 self, 01 loop-int, 10 bypass, 11 loop-ext.
// - status follows a select write only after several cycles, never the same cycle.
// - first control write without ref select and 1x request locks ref select low.
// - grant self unless leaving bypass before dco stable; loop-int on dco stable; bypass on ext ok.
// - ungrantable requests keep self, loop-int, bypass or off as the conditions say.
// - self-clocked output ignores the reference; comparisons still use internal ref.
// - loop-ext output is dco over R after lock, over 2R while locking.
// - loop-ext fixed clock is ext ref over 2 when P*N/R >= 4 and locked.
// - otherwise the fixed clock follows the internal bus clock in bypass, off and loop-ext; self and loop-int hold it low.
// - high gain selects the strong oscillator, effective only with ref select set.
// - high gain is writable once after reset; later writes are ignored.
// - self-clocked output is the dco clock divided by R.
// - bypass output is the external reference divided by R, no multiplication.
// - loop-internal target is internal ref over 7, times 64, times N, over R.
// - loop-external target is ext times P times N over R, P 64 or 1.
// - mult field decodes to N 4..18 by twos, div field to R 1..128.
// - ext ok follows the real reference only while it is monitored.
// - clock loss in loop-ext with ext ok falls back to bypass, status 10.
module clock_mode_select_and_status
    import clock_mode_pkg::*;
#(
    parameter int SETTLE = `SETTLE_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic dco_stable_in,
    input wire logic ext_ref_meet_in,
    input wire logic clock_loss_in,
    input wire logic fll_locked_in,
    input wire logic stop_in,
    input wire logic dco_tick_in,
    input wire logic ext_tick_in,
    input wire logic bus_tick_in,
    output logic clock_gen_out,
    output logic fixed_freq_clk_out,
    output logic [1:0] clock_status_out,
    output logic osc_amp_en_out,
    output logic high_gain_out,
    output logic loop_engage_out,
    output logic loop_ref_ext_out,
    output logic [10:0] loop_mult_out,
    output logic [2:0] loop_ref_div_out
);
    if (SETTLE < 4 || SETTLE > 15) begin : g_settle_check
        $error("clock_mode_select_and_status: SETTLE must be 4..15");
    end

    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [`SYNC_W-1:0] sync1_r;
    logic [`SYNC_W-1:0] sync2_r;
    logic dco_s, ext_meet_s, loss_s, locked_s, stop_s;
    logic setup, access, wr_c1, wr_c2, rd_map, ro_hit;
    logic [31:0] rdata;
    logic [1:0] req_r;
    logic ref_select_r, ref_lock_r, high_gain_r, first_done_r, range_r;
    logic [2:0] mult_r, div_r;
    logic [3:0] settle_r;
    logic upd, ext_ok, seen_lock_r, ratio_ok, fixed_half, half;
    clk_mode_t mode_r, mode_nxt;
    logic [4:0] n_val;
    logic [10:0] pn;
    logic [3:0] gen_shift;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {stop_in, fll_locked_in, clock_loss_in, ext_ref_meet_in, dco_stable_in};
            sync2_r <= sync1_r;
        end
    end
    assign {stop_s, locked_s, loss_s, ext_meet_s, dco_s} = sync2_r;

    // apb decode, one wait-free access phase
    assign setup = psel_in && !penable_in;
    assign access = psel_in && penable_in && pready_out;
    assign wr_c1 = access && pwrite_in && pstrb_in[0] && paddr_in == `OFS_CTRL1;
    assign wr_c2 = access && pwrite_in && pstrb_in[0] && paddr_in == `OFS_CTRL2;
    assign ro_hit = paddr_in == `OFS_STATUS || paddr_in == `OFS_LOOP;
    assign rd_map = paddr_in == `OFS_CTRL1 || paddr_in == `OFS_CTRL2 || ro_hit;

    always_comb begin
        rdata = 32'h0;
        unique case (paddr_in)
            `OFS_CTRL1: rdata = {24'h0, high_gain_r, range_r, ref_select_r, req_r, 3'h0};
            `OFS_CTRL2: rdata = {25'h0, mult_r, 1'b0, div_r};
            `OFS_STATUS: rdata = {24'h0, ref_lock_r, ratio_ok, locked_s, loss_s,
                                  ext_ok, dco_s, clock_status_out};
            `OFS_LOOP: rdata = {21'h0, pn};
            default: rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else begin
            pready_out <= setup;
            pslverr_out <= setup && (!rd_map || (pwrite_in && ro_hit));
            if (setup) begin
                prdata_out <= pwrite_in ? 32'h0 : rdata;
            end
        end
    end

    // first control write decides ref select lock and high gain
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            req_r <= `SEL_SELF;
            range_r <= 1'b0;
            ref_select_r <= 1'b0;
            ref_lock_r <= 1'b0;
            high_gain_r <= 1'b0;
            first_done_r <= 1'b0;
        end else if (wr_c1) begin
            req_r <= pwdata_in[`C1_SEL];
            range_r <= pwdata_in[`C1_RANGE];
            if (!first_done_r) begin
                first_done_r <= 1'b1;
                high_gain_r <= pwdata_in[`C1_HIGH_GAIN];
                ref_select_r <= pwdata_in[`C1_REF_SEL] && pwdata_in[`C1_SEL_HI];
                ref_lock_r <= !(pwdata_in[`C1_REF_SEL] && pwdata_in[`C1_SEL_HI]);
            end else begin
                ref_select_r <= pwdata_in[`C1_REF_SEL] && !ref_lock_r;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mult_r <= `FIELD3_RST;
            div_r <= `FIELD3_RST;
        end else if (wr_c2) begin
            mult_r <= pwdata_in[`C2_MULT];
            div_r <= pwdata_in[`C2_DIV];
        end
    end

    // settling delay after a select write
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            settle_r <= 4'h0;
        end else if (wr_c1) begin
            settle_r <= 4'(SETTLE);
        end else if (settle_r != 4'h0) begin
            settle_r <= settle_r - 4'h1;
        end
    end
    assign upd = settle_r == 4'h0 && !wr_c1;

    // reference monitoring: forced low, forced high or real time
    always_comb begin
        if (!req_r[1]) begin
            ext_ok = 1'b0;
        end else if (req_r == `SEL_BYPASS && !ref_select_r) begin
            ext_ok = 1'b1;
        end else begin
            ext_ok = ext_meet_s;
        end
    end

    always_comb begin
        mode_nxt = mode_r;
        if (stop_s) begin
            mode_nxt = M_OFF;
        end else begin
            unique case (req_r)
                `SEL_SELF: mode_nxt = (mode_r == M_BYPASS && !dco_s) ? M_BYPASS : M_SELF;
                `SEL_LOOP_INT: mode_nxt = dco_s ? M_LOOP_INT : M_SELF;
                `SEL_BYPASS: begin
                    if (ext_ok) begin
                        mode_nxt = M_BYPASS;
                    end else begin
                        mode_nxt = (mode_r == M_OFF) ? M_OFF : M_SELF;
                    end
                end
                `SEL_LOOP_EXT: begin
                    if (loss_s && ext_ok && (mode_r == M_LOOP_EXT || mode_r == M_BYPASS)) begin
                        mode_nxt = M_BYPASS;
                    end else if (dco_s && ext_ok && !loss_s) begin
                        mode_nxt = M_LOOP_EXT;
                    end else if (dco_s && !loss_s && mode_r == M_LOOP_INT) begin
                        mode_nxt = M_LOOP_INT;
                    end else begin
                        mode_nxt = M_SELF;
                    end
                end
            endcase
        end
    end

    function automatic logic [1:0] code_of(input clk_mode_t m);
        unique case (m)
            M_SELF: code_of = `SEL_SELF;
            M_LOOP_INT: code_of = `SEL_LOOP_INT;
            M_BYPASS: code_of = `SEL_BYPASS;
            M_LOOP_EXT: code_of = `SEL_LOOP_EXT;
            default: code_of = `CODE_OFF;
        endcase
    endfunction

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= M_SELF;
            clock_status_out <= `SEL_SELF;
        end else if (upd) begin
            mode_r <= mode_nxt;
            clock_status_out <= code_of(mode_nxt);
        end
    end

    // first lock tracking for the extra halving
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            seen_lock_r <= 1'b0;
        end else if (mode_r != M_LOOP_EXT || (wr_c2 && pwdata_in[`C2_MULT] != mult_r)) begin
            seen_lock_r <= 1'b0;
        end else if (locked_s) begin
            seen_lock_r <= 1'b1;
        end
    end

    assign n_val = {1'b0, mult_r, 1'b0} + `N_BASE;
    assign pn = range_r ? {6'h0, n_val} : 11'({n_val, 6'h0});
    assign ratio_ok = {1'b0, pn} >= (`RATIO_MIN << div_r);
    assign half = mode_r == M_LOOP_EXT && !seen_lock_r;
    assign gen_shift = {1'b0, div_r} + {3'h0, half};
    assign fixed_half = mode_r == M_LOOP_EXT && ratio_ok && locked_s;

    tick_divider #(
        .SHIFT_W(4),
        .CNT_W(8)
    ) u_gen_div (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .en_in(mode_r != M_OFF),
        .tick_in(mode_r == M_BYPASS ? ext_tick_in : dco_tick_in),
        .shift_in(gen_shift),
        .tick_out(clock_gen_out)
    );

    tick_divider #(
        .SHIFT_W(4),
        .CNT_W(8)
    ) u_fixed_div (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .en_in(mode_r != M_LOOP_INT && mode_r != M_SELF),
        .tick_in(fixed_half ? ext_tick_in : bus_tick_in),
        .shift_in(fixed_half ? `FIXED_HALF : `FIXED_FULL),
        .tick_out(fixed_freq_clk_out)
    );

    // oscillator and loop steering
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            osc_amp_en_out <= 1'b0;
            high_gain_out <= 1'b0;
            loop_engage_out <= 1'b0;
            loop_ref_ext_out <= 1'b0;
            loop_mult_out <= 11'h0;
            loop_ref_div_out <= `REF_DIV_INT;
        end else begin
            osc_amp_en_out <= ref_select_r && req_r[1];
            high_gain_out <= high_gain_r && ref_select_r;
            loop_engage_out <= mode_r == M_LOOP_INT || mode_r == M_LOOP_EXT;
            loop_ref_ext_out <= mode_r == M_LOOP_EXT;
            loop_mult_out <= (mode_r == M_LOOP_EXT) ? pn : 11'({n_val, 6'h0});
            loop_ref_div_out <= (mode_r == M_LOOP_EXT) ? `REF_DIV_EXT : `REF_DIV_INT;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    AST_STATUS_CODE:
    assert property ((mode_r == M_LOOP_EXT) |-> (clock_status_out == `SEL_LOOP_EXT))
        else $error("status code does not match loop-external mode");
    AST_STATUS_DELAY:
    assert property (wr_c1 |=> $stable(clock_status_out)[*3])
        else $error("status changed too soon after select write");
    AST_REF_LOCKED:
    assert property (ref_lock_r |-> !ref_select_r && !osc_amp_en_out)
        else $error("ref select escaped its lock");
    AST_GRANT_LOOP_INT:
    assert property ((upd && !stop_s && req_r == `SEL_LOOP_INT && dco_s)
                     |=> mode_r == M_LOOP_INT)
        else $error("loop-internal not granted");
    AST_STAY_OFF:
    assert property ((upd && !stop_s && req_r == `SEL_BYPASS && !ext_ok && mode_r == M_OFF)
                     |=> mode_r == M_OFF)
        else $error("left off state without ext ok");
    AST_BYPASS_FALLBACK:
    assert property ((upd && !stop_s && req_r == `SEL_LOOP_EXT && mode_r == M_LOOP_EXT
                      && loss_s && ext_ok)
                     |=> (mode_r == M_BYPASS && clock_status_out == `SEL_BYPASS))
        else $error("no bypass fallback on clock loss");
    AST_FIXED_OFF:
    assert property ((mode_r == M_LOOP_INT || mode_r == M_SELF) |=> !fixed_freq_clk_out)
        else $error("fixed clock ran in internal mode");
    AST_HIGH_GAIN_ONCE:
    assert property ((wr_c1 && first_done_r) |=> $stable(high_gain_r))
        else $error("high gain rewritten");
    AST_OFF_SILENT:
    assert property ((mode_r == M_OFF) |=> !clock_gen_out)
        else $error("output ticked in off state");
    AST_EXT_FORCED_LOW:
    assert property (!req_r[1] |-> !ext_ok)
        else $error("ext ok not forced low");
    AST_HALF_RATE:
    assert property ((mode_r == M_LOOP_EXT && !seen_lock_r) |-> gen_shift == {1'b0, div_r} + 4'h1)
        else $error("no extra halving while locking");
endmodule

//--- testbench/clock_consumer_model.sv
`timescale 1ns/1ps
module clock_consumer_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [1:0] clock_status_in,
    input wire logic fixed_freq_clk_in,
    output logic dco_tick_out,
    output logic ext_tick_out,
    output logic bus_tick_out,
    output logic fixed_in_use_out
);
    logic ext_ph_r;
    logic [1:0] bus_cnt_r;
    // dco every cycle, ext ref every 2nd, bus every 3rd
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ext_ph_r <= 1'b0;
            bus_cnt_r <= 2'h0;
        end else begin
            ext_ph_r <= ~ext_ph_r;
            bus_cnt_r <= (bus_cnt_r == 2'h2) ? 2'h0 : bus_cnt_r + 2'h1;
        end
    end
    assign dco_tick_out = 1'b1;
    assign ext_tick_out = ext_ph_r;
    assign bus_tick_out = (bus_cnt_r == 2'h0);
    // fixed clock ignored in self-clocked and loop-internal modes
    assign fixed_in_use_out = fixed_freq_clk_in & clock_status_in[1];
endmodule

//--- testbench/test_clock_mode_select_and_status.sv
`timescale 1ns/1ps
module test_clock_mode_select_and_status;
    logic clk_in = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic dco_ok = 1'b0;
    logic ext_meet = 1'b0;
    logic loss = 1'b0;
    logic locked = 1'b0;
    logic stop = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, dco_tick, ext_tick, bus_tick, gen, fixed, amp_en, high_gain, engage;
    logic ref_ext;
    logic [1:0] status;
    logic [10:0] mult;
    logic [2:0] ref_div;
    logic [31:0] rd;
    logic err;
    int err_total = 0;
    int cmp_count = 0;
    int gen_n;
    int fix_n;

    always #2 clk_in = ~clk_in;

    clock_mode_select_and_status i_dut (
        .clk_in(clk_in), .reset_n_in(reset_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .dco_stable_in(dco_ok), .ext_ref_meet_in(ext_meet), .clock_loss_in(loss),
        .fll_locked_in(locked), .stop_in(stop), .dco_tick_in(dco_tick),
        .ext_tick_in(ext_tick), .bus_tick_in(bus_tick), .clock_gen_out(gen),
        .fixed_freq_clk_out(fixed), .clock_status_out(status), .osc_amp_en_out(amp_en),
        .high_gain_out(high_gain), .loop_engage_out(engage), .loop_ref_ext_out(ref_ext),
        .loop_mult_out(mult), .loop_ref_div_out(ref_div)
    );

    clock_consumer_model i_consumer (
        .clk_in(clk_in), .reset_n_in(reset_n), .clock_status_in(status),
        .fixed_freq_clk_in(fixed), .dco_tick_out(dco_tick), .ext_tick_out(ext_tick),
        .bus_tick_out(bus_tick), .fixed_in_use_out()
    );

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // apb transfer, holds the request until pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk_in);
            n++;
        end
        if (pready !== 1'b1) begin
            err_total++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle;
        repeat (20) @(posedge clk_in);
    endtask

    task automatic count(input int cyc);
        gen_n = 0;
        fix_n = 0;
        repeat (cyc) begin
            @(posedge clk_in);
            if (gen === 1'b1) gen_n++;
            if (fixed === 1'b1) fix_n++;
        end
    endtask

    task automatic do_reset;
        @(posedge clk_in);
        reset_n <= 1'b0;
        dco_ok <= 1'b0;
        ext_meet <= 1'b0;
        loss <= 1'b0;
        locked <= 1'b0;
        stop <= 1'b0;
        repeat (20) @(posedge clk_in);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_in);
    endtask

    task automatic t_reset;
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0);
        check(status, 2'h0);
        check(ref_div, 3'h7);
        check(mult, 11'h100);
        check(engage, 1'b0);
        check(ref_ext, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        check(err, 1'b1);
        apb(1'b1, 12'h008, 32'h3);
        check(err, 1'b1);
    endtask

    task automatic t_decode;
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, 12'h004, 32'(k * 17));
            apb(1'b0, 12'h00c, 32'h0);
            check(rd, 64 * (4 + 2 * k));
            check(mult, 64 * (4 + 2 * k));
            repeat (256) @(posedge clk_in);
            count(256);
            check(gen_n, 256 >> k);
        end
        apb(1'b1, 12'h004, 32'h0);
    endtask

    task automatic t_gain;
        apb(1'b1, 12'h000, 32'hb0);
        settle;
        check(amp_en, 1'b1);
        check(high_gain, 1'b1);
        apb(1'b1, 12'h000, 32'h30);
        settle;
        check(high_gain, 1'b1);
        ext_meet <= 1'b1;
        settle;
        check(status, 2'h2);
        count(240);
        check(gen_n, 120);
        check(fix_n, 80);
        apb(1'b1, 12'h000, 32'h20);
        settle;
        check(status, 2'h2);
        dco_ok <= 1'b1;
        settle;
        check(status, 2'h0);
        count(240);
        check(gen_n, 240);
        check(fix_n, 0);
        stop <= 1'b1;
        ext_meet <= 1'b0;
        settle;
        apb(1'b1, 12'h000, 32'h30);
        stop <= 1'b0;
        settle;
        count(240);
        check(gen_n, 0);
    endtask

    task automatic t_loop;
        do_reset;
        dco_ok <= 1'b1;
        apb(1'b1, 12'h000, 32'h08);
        repeat (3) @(negedge clk_in);
        check(status, 2'h0);
        settle;
        check(status, 2'h1);
        check(engage, 1'b1);
        count(240);
        check(fix_n, 0);
        apb(1'b1, 12'h000, 32'h38);
        settle;
        check(amp_en, 1'b0);
        check(status, 2'h1);
        ext_meet <= 1'b1;
        settle;
        check(status, 2'h3);
        check(ref_div, 3'h1);
        check(ref_ext, 1'b1);
        check(mult, 11'h100);
        count(240);
        check(gen_n, 120);
        check(fix_n, 80);
        locked <= 1'b1;
        settle;
        count(240);
        check(gen_n, 240);
        check(fix_n, 60);
        apb(1'b1, 12'h004, 32'h07);
        settle;
        count(240);
        check(fix_n, 80);
        apb(1'b1, 12'h000, 32'h78);
        settle;
        check(mult, 11'h004);
        loss <= 1'b1;
        settle;
        check(status, 2'h2);
        stop <= 1'b1;
        settle;
        check(status, 2'h0);
        count(240);
        check(gen_n, 0);
    endtask

    initial begin
        do_reset;
        t_reset;
        t_decode;
        t_gain;
        t_loop;
        give_verdict;
    end

    initial begin
        #100000;
        err_total++;
        give_verdict;
    end
endmodule
